// [rtl/astr_pkg.sv]
package astr_pkg;

    // register map (byte offsets on the 3-bit register port)
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_DATA   = 3'h1;
    localparam logic [2:0] ADDR_CTRL1  = 3'h2;
    localparam logic [2:0] ADDR_CTRL2  = 3'h3;
    localparam logic [2:0] ADDR_DIV_LO = 3'h4;
    localparam logic [2:0] ADDR_DIV_HI = 3'h5;

    // status bit positions
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_TX_DONE  = 6;
    localparam int ST_RX_FULL  = 5;
    localparam int ST_IDLE     = 4;
    localparam int ST_OVERRUN  = 3;
    localparam int ST_NOISE    = 2;
    localparam int ST_FRAMING  = 1;

    // control 1 bit positions
    localparam int C1_RX_NINTH = 7;
    localparam int C1_TX_NINTH = 6;
    localparam int C1_WORD_LEN = 4;

    // control 2 bit positions
    localparam int C2_TX_IRQ_EN   = 7;
    localparam int C2_TC_IRQ_EN   = 6;
    localparam int C2_RX_IRQ_EN   = 5;
    localparam int C2_IDLE_IRQ_EN = 4;
    localparam int C2_TX_EN       = 3;
    localparam int C2_RX_ON       = 2;
    localparam int C2_SEND_BREAK  = 0;

    // sample divisor: clk cycles per oversample tick
    localparam logic [15:0] DIV_RESET = 16'h001b;

    // oversampling: 16 samples per bit, samples 8, 9, 10 are voted
    localparam logic [3:0] SUB_LAST  = 4'hf;
    localparam logic [3:0] SUB_SMP8  = 4'h7;
    localparam logic [3:0] SUB_SMP9  = 4'h8;
    localparam logic [3:0] SUB_SMP10 = 4'h9;

    // frame lengths in bits (start + data + stop) and data bit counts
    localparam logic [3:0] FRAME_LEN_8 = 4'ha;
    localparam logic [3:0] FRAME_LEN_9 = 4'hb;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;

    typedef enum logic [0:0] {
        ASTR_TX_IDLE = 1'b0,
        ASTR_TX_SEND = 1'b1
    } astr_tx_state_t;

    typedef enum logic [1:0] {
        ASTR_RX_HUNT  = 2'b00,
        ASTR_RX_START = 2'b01,
        ASTR_RX_DATA  = 2'b10,
        ASTR_RX_STOP  = 2'b11
    } astr_rx_state_t;

endpackage

// [rtl/astr_core.sv]
`timescale 1ns/100ps

// Behaviour
// RULE_01: status access then data write clears tx_buffer_empty and tx_complete together; here any data write clears tx_buffer_empty.
// RULE_02: send_break loads the shifter with an all-zero frame of selected length.
// RULE_03: break frames repeat while send_break set; one 1 bit follows the last.
// RULE_04: enabling the transmitter sends one idle frame before the first data.
// RULE_05: transmit_enable toggled mid-frame sends an idle frame after the current word.
// RULE_06: toggling transmit_enable discards the pending holding byte.
// RULE_07: receive 8 or 9 bit words; ninth bit goes to rx_ninth_bit.
// RULE_08: received bits shift in lsb first into a holding buffer.
// RULE_09: rx_on enables the receiver, which hunts for a start bit.
// RULE_10: a character moves to the holding buffer, sets rx_buffer_full, may interrupt.
// RULE_11: status access then data read clears rx_buffer_full.
// RULE_12: software clears rx_buffer_full before the next character ends.
// RULE_13: a received break is reported as a framing error.
// RULE_14: an idle frame is flagged and interrupts when its enable is set.
// RULE_15: completion while full sets overrun and keeps the holding buffer.
// RULE_16: status access then data read clears overrun.
// RULE_17: samples 8, 9 and 10 of each data bit must agree, else noise.
// RULE_18: start bit noise combines a valid falling edge with sample agreement.
// RULE_19: noise rises with rx_buffer_full, data delivered, no separate interrupt.
// RULE_20: status read then data read clears noise_flag.
// RULE_21: start samples 011, 101, 110 drop the frame; noise shows with next one.
// RULE_22: transmit 8 or 9 bit words; ninth bit comes from tx_ninth_bit.
// RULE_23: after the stop bit tx_complete sets and may interrupt.
// RULE_24: the receiver takes sixteen samples per bit.
module astr_core (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       irq_mask,
    input  wire logic       rx_data_pin,
    output logic            tx_data_pin,
    output logic            irq
);

    typedef struct packed {
        logic                  word_len;
        logic                  tx_ninth_bit;
        logic                  rx_ninth_bit;
        logic                  tie;
        logic                  tcie;
        logic                  rx_irq_enable;
        logic                  idle_line_irq_enable;
        logic                  te;
        logic                  rx_on;
        logic                  send_break;
        logic [15:0]           div;
        logic [15:0]           baud_cnt;
        logic                  armed;
        logic [7:0]            rdata;
        logic                  irq;
        astr_pkg::astr_tx_state_t tx_state;
        logic [10:0]           tx_shift;
        logic [3:0]            tx_bits;
        logic [3:0]            tx_sub;
        logic                  tx_count_done;
        logic [7:0]            tx_hold;
        logic                  tx_buffer_empty;
        logic                  tc;
        logic                  idle_pend;
        logic                  tail_pend;
        logic                  te_prev;
        logic                  tx_pin;
        astr_pkg::astr_rx_state_t rx_state;
        logic [3:0]            rx_sub;
        logic [3:0]            rx_bit;
        logic [8:0]            rx_sh;
        logic                  rx_prev;
        logic [1:0]            smp;
        logic                  noise_frame;
        logic                  noise_pend;
        logic [7:0]            rx_holding_buffer;
        logic                  rx_buffer_full;
        logic                  orf;
        logic                  nf;
        logic                  fe;
        logic                  idle;
        logic [7:0]            idle_cnt;
        logic                  idle_armed;
    } astr_state_t;

    astr_state_t s_ff;
    astr_state_t nxt_s;

    logic       tick;
    logic [3:0] frame_len;
    logic [3:0] data_bits;
    logic [3:0] rx_nsub;
    logic [2:0] votes;
    logic       maj;
    logic       disagree;
    logic       rx_eval;
    logic [7:0] status_byte;

    always_comb begin
        tick        = (s_ff.baud_cnt == 16'h0);
        frame_len   = s_ff.word_len ? astr_pkg::FRAME_LEN_9 : astr_pkg::FRAME_LEN_8;
        data_bits   = s_ff.word_len ? astr_pkg::DATA_BITS_9 : astr_pkg::DATA_BITS_8;
        rx_nsub     = s_ff.rx_sub + 4'h1;
        votes       = {s_ff.smp[0], s_ff.smp[1], rx_data_pin};
        maj         = (votes[2] & votes[1]) | (votes[2] & votes[0]) | (votes[1] & votes[0]);
        disagree    = ~((&votes) | ~(|votes));
        rx_eval     = tick && (s_ff.rx_state != astr_pkg::ASTR_RX_HUNT)
                      && (rx_nsub == astr_pkg::SUB_SMP10);
        status_byte = {s_ff.tx_buffer_empty, s_ff.tc, s_ff.rx_buffer_full, s_ff.idle,
                       s_ff.orf, s_ff.nf, s_ff.fe, 1'b0};
    end

    always_comb begin
        nxt_s = s_ff;
        // a zero divisor wraps to the longest tick period
        nxt_s.baud_cnt = tick ? s_ff.div - 16'h1 : s_ff.baud_cnt - 16'h1;
        nxt_s.rdata    = 8'h00;

        // register port; clears come first so hardware sets below win
        if (rd && addr == astr_pkg::ADDR_STATUS) begin
            nxt_s.rdata = status_byte;
            nxt_s.armed = 1'b1;
        end else if (wr && addr == astr_pkg::ADDR_STATUS) begin
            nxt_s.armed = 1'b1;
        end else if (rd && addr == astr_pkg::ADDR_DATA) begin
            nxt_s.rdata = s_ff.rx_holding_buffer;
            if (s_ff.armed) begin
                nxt_s.rx_buffer_full  = 1'b0; // RULE_11
                nxt_s.orf   = 1'b0; // RULE_16
                nxt_s.nf    = 1'b0; // RULE_20
                nxt_s.fe    = 1'b0;
                nxt_s.idle  = 1'b0;
                nxt_s.armed = 1'b0;
            end
        end else if (wr && addr == astr_pkg::ADDR_DATA) begin
            nxt_s.tx_hold      = wdata;
            nxt_s.tx_buffer_empty         = 1'b0;
            nxt_s.tx_ninth_bit = s_ff.tx_ninth_bit;
            if (s_ff.armed) begin
                nxt_s.tc    = 1'b0; // RULE_01
                nxt_s.armed = 1'b0;
            end
        end else if (rd && addr == astr_pkg::ADDR_CTRL1) begin
            nxt_s.rdata = {s_ff.rx_ninth_bit, s_ff.tx_ninth_bit, 1'b0, s_ff.word_len, 4'h0};
        end else if (wr && addr == astr_pkg::ADDR_CTRL1) begin
            nxt_s.tx_ninth_bit = wdata[astr_pkg::C1_TX_NINTH];
            nxt_s.word_len     = wdata[astr_pkg::C1_WORD_LEN];
        end else if (rd && addr == astr_pkg::ADDR_CTRL2) begin
            nxt_s.rdata = {s_ff.tie, s_ff.tcie, s_ff.rx_irq_enable, s_ff.idle_line_irq_enable,
                           s_ff.te, s_ff.rx_on, 1'b0, s_ff.send_break};
        end else if (wr && addr == astr_pkg::ADDR_CTRL2) begin
            nxt_s.tie   = wdata[astr_pkg::C2_TX_IRQ_EN];
            nxt_s.tcie  = wdata[astr_pkg::C2_TC_IRQ_EN];
            nxt_s.rx_irq_enable   = wdata[astr_pkg::C2_RX_IRQ_EN];
            nxt_s.idle_line_irq_enable  = wdata[astr_pkg::C2_IDLE_IRQ_EN];
            nxt_s.te    = wdata[astr_pkg::C2_TX_EN];
            nxt_s.rx_on = wdata[astr_pkg::C2_RX_ON];
            nxt_s.send_break   = wdata[astr_pkg::C2_SEND_BREAK];
        end else if (rd && addr == astr_pkg::ADDR_DIV_LO) begin
            nxt_s.rdata = s_ff.div[7:0];
        end else if (wr && addr == astr_pkg::ADDR_DIV_LO) begin
            nxt_s.div[7:0] = wdata;
        end else if (rd && addr == astr_pkg::ADDR_DIV_HI) begin
            nxt_s.rdata = s_ff.div[15:8];
        end else if (wr && addr == astr_pkg::ADDR_DIV_HI) begin
            nxt_s.div[15:8] = wdata;
        end

        // transmitter enable edges
        nxt_s.te_prev = s_ff.te;
        if (s_ff.te != s_ff.te_prev) begin
            nxt_s.tx_buffer_empty = 1'b1; // RULE_06
        end
        if (s_ff.te && !s_ff.te_prev) begin
            nxt_s.idle_pend = 1'b1; // RULE_04 RULE_05
        end

        // transmitter; a toggle mid-frame lets the current frame finish first
        nxt_s.tx_count_done = 1'b0;
        case (s_ff.tx_state)
            astr_pkg::ASTR_TX_IDLE: begin
                if (s_ff.te && s_ff.te_prev) begin
                    nxt_s.tx_sub = 4'h0;
                    if (s_ff.send_break) begin
                        nxt_s.tx_shift  = 11'h000; // RULE_02
                        nxt_s.tx_bits   = frame_len;
                        nxt_s.tail_pend = 1'b1;
                        nxt_s.tx_state  = astr_pkg::ASTR_TX_SEND;
                    end else if (s_ff.tail_pend) begin
                        nxt_s.tx_shift  = 11'h7ff; // RULE_03
                        nxt_s.tx_bits   = 4'h1;
                        nxt_s.tail_pend = 1'b0;
                        nxt_s.tx_state  = astr_pkg::ASTR_TX_SEND;
                    end else if (s_ff.idle_pend && !(s_ff.te && !s_ff.te_prev)) begin
                        nxt_s.tx_shift  = 11'h7ff; // RULE_04 RULE_05
                        nxt_s.tx_bits   = frame_len;
                        nxt_s.idle_pend = 1'b0;
                        nxt_s.tx_state  = astr_pkg::ASTR_TX_SEND;
                    end else if (!s_ff.tx_buffer_empty && !s_ff.idle_pend) begin
                        nxt_s.tx_shift  = s_ff.word_len ?
                                          {1'b1, s_ff.tx_ninth_bit, s_ff.tx_hold, 1'b0} :
                                          {2'b11, s_ff.tx_hold, 1'b0}; // RULE_22
                        nxt_s.tx_bits   = frame_len;
                        nxt_s.tx_buffer_empty      = 1'b1;
                        nxt_s.tx_state  = astr_pkg::ASTR_TX_SEND;
                    end
                end
            end
            astr_pkg::ASTR_TX_SEND: begin
                if (tick) begin
                    nxt_s.tx_sub = s_ff.tx_sub + 4'h1;
                    if (s_ff.tx_sub == astr_pkg::SUB_LAST) begin
                        nxt_s.tx_shift = {1'b1, s_ff.tx_shift[10:1]};
                        nxt_s.tx_bits  = s_ff.tx_bits - 4'h1;
                        if (s_ff.tx_bits == 4'h1) begin
                            nxt_s.tx_state      = astr_pkg::ASTR_TX_IDLE;
                            nxt_s.tc            = 1'b1; // RULE_23
                            nxt_s.tx_count_done = 1'b1;
                        end
                    end
                end
            end
            default: nxt_s.tx_state = astr_pkg::ASTR_TX_IDLE;
        endcase
        // a running break keeps the line low through the gap between repeated frames
        nxt_s.tx_pin = (nxt_s.tx_state == astr_pkg::ASTR_TX_SEND) ? nxt_s.tx_shift[0]
                       : ~(nxt_s.tail_pend & nxt_s.send_break & nxt_s.te); // RULE_03

        // receiver, sixteen ticks per bit
        if (!s_ff.rx_on) begin
            nxt_s.rx_state   = astr_pkg::ASTR_RX_HUNT;
            nxt_s.rx_prev    = 1'b1;
            nxt_s.idle_cnt   = 8'h00;
            nxt_s.idle_armed = 1'b0;
        end else if (tick) begin // RULE_09 RULE_24
            case (s_ff.rx_state)
                astr_pkg::ASTR_RX_HUNT: begin
                    nxt_s.rx_prev = rx_data_pin;
                    if (s_ff.rx_prev && !rx_data_pin) begin
                        // falling edge is the first half of start validation
                        nxt_s.rx_state    = astr_pkg::ASTR_RX_START; // RULE_18
                        nxt_s.rx_sub      = 4'h0;
                        nxt_s.noise_frame = 1'b0;
                        nxt_s.idle_cnt    = 8'h00;
                        nxt_s.idle_armed  = 1'b1;
                    end else if (rx_data_pin && s_ff.idle_armed) begin
                        nxt_s.idle_cnt = s_ff.idle_cnt + 8'h01;
                        if (s_ff.idle_cnt + 8'h01 == {frame_len, 4'h0}) begin
                            nxt_s.idle       = 1'b1; // RULE_14
                            nxt_s.idle_armed = 1'b0;
                        end
                    end else begin
                        nxt_s.idle_cnt = 8'h00;
                    end
                end
                default: begin
                    nxt_s.rx_sub = rx_nsub;
                    if (rx_nsub == astr_pkg::SUB_SMP8) begin
                        nxt_s.smp[0] = rx_data_pin;
                    end else if (rx_nsub == astr_pkg::SUB_SMP9) begin
                        nxt_s.smp[1] = rx_data_pin;
                    end
                    if (rx_eval) begin
                        case (s_ff.rx_state)
                            astr_pkg::ASTR_RX_START: begin
                                if (maj) begin
                                    nxt_s.rx_state = astr_pkg::ASTR_RX_HUNT;
                                    nxt_s.rx_prev  = rx_data_pin;
                                    nxt_s.noise_pend = s_ff.noise_pend | disagree; // RULE_21
                                end else begin
                                    nxt_s.noise_frame = disagree; // RULE_18
                                end
                            end
                            astr_pkg::ASTR_RX_DATA: begin
                                nxt_s.rx_sh[s_ff.rx_bit] = maj; // RULE_08
                                nxt_s.noise_frame = s_ff.noise_frame | disagree; // RULE_17
                            end
                            default: begin
                                nxt_s.rx_state = astr_pkg::ASTR_RX_HUNT;
                                nxt_s.rx_prev  = rx_data_pin;
                                if (nxt_s.rx_buffer_full) begin
                                    nxt_s.orf = 1'b1; // RULE_15
                                end else begin
                                    nxt_s.rx_holding_buffer  = s_ff.rx_sh[7:0]; // RULE_10
                                    nxt_s.rx_buffer_full = 1'b1;
                                    if (s_ff.word_len) begin
                                        nxt_s.rx_ninth_bit = s_ff.rx_sh[8]; // RULE_07
                                    end
                                    nxt_s.fe = ~maj; // RULE_13
                                    nxt_s.nf = s_ff.noise_frame | disagree
                                               | s_ff.noise_pend; // RULE_19 RULE_21
                                    nxt_s.noise_pend = 1'b0;
                                end
                            end
                        endcase
                    end
                    if (s_ff.rx_sub == astr_pkg::SUB_LAST) begin
                        nxt_s.rx_sub = 4'h0;
                        if (s_ff.rx_state == astr_pkg::ASTR_RX_START) begin
                            nxt_s.rx_state = astr_pkg::ASTR_RX_DATA;
                            nxt_s.rx_bit   = 4'h0;
                            nxt_s.rx_sh    = 9'h000;
                        end else if (s_ff.rx_state == astr_pkg::ASTR_RX_DATA) begin
                            nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
                            if (s_ff.rx_bit + 4'h1 == data_bits) begin
                                nxt_s.rx_state = astr_pkg::ASTR_RX_STOP;
                            end
                        end
                    end
                end
            endcase
        end

        // noise has no enable of its own; it rides on the receive request
        nxt_s.irq = ~irq_mask & ((nxt_s.tie & nxt_s.tx_buffer_empty) | (nxt_s.tcie & nxt_s.tc)
                    | (nxt_s.rx_irq_enable & (nxt_s.rx_buffer_full | nxt_s.orf))
                    | (nxt_s.idle_line_irq_enable & nxt_s.idle)); // RULE_10 RULE_14 RULE_15 RULE_23

        // synchronous reset overrides every next value
        if (!rst_n) begin
            nxt_s          = '0;
            nxt_s.div      = astr_pkg::DIV_RESET;
            nxt_s.tx_buffer_empty     = 1'b1;
            nxt_s.tc       = 1'b1;
            nxt_s.tx_pin   = 1'b1;
            nxt_s.rx_prev  = 1'b1;
            nxt_s.tx_state = astr_pkg::ASTR_TX_IDLE;
            nxt_s.rx_state = astr_pkg::ASTR_RX_HUNT;
        end
    end

    always_ff @(posedge clk) begin
        s_ff <= nxt_s;
    end

    assign rdata       = s_ff.rdata;
    assign tx_data_pin = s_ff.tx_pin;
    assign irq         = s_ff.irq;

    // checks
    logic rx_done;
    logic data_rd_clr;
    assign rx_done     = rx_eval && (s_ff.rx_state == astr_pkg::ASTR_RX_STOP);
    assign data_rd_clr = rd && (addr == astr_pkg::ADDR_DATA) && s_ff.armed;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    tx_flag_clear_a: assert property (wr && addr == astr_pkg::ADDR_DATA && s_ff.armed // RULE_01
        && !(s_ff.tx_state == astr_pkg::ASTR_TX_SEND && tick
             && s_ff.tx_sub == astr_pkg::SUB_LAST && s_ff.tx_bits == 4'h1)
        |=> !s_ff.tc)
        else $error("tx_complete not cleared by status and data write");
    break_load_a: assert property ($rose(s_ff.send_break) && s_ff.te && s_ff.te_prev // RULE_02
        && s_ff.tx_state == astr_pkg::ASTR_TX_IDLE
        |=> s_ff.tx_state == astr_pkg::ASTR_TX_SEND && !tx_data_pin)
        else $error("break frame not started low");
    break_tail_a: assert property (s_ff.tail_pend && !s_ff.send_break && s_ff.te && s_ff.te_prev // RULE_03
        && s_ff.tx_state == astr_pkg::ASTR_TX_IDLE
        |=> tx_data_pin && s_ff.tx_bits == 4'h1)
        else $error("stop bit after break missing");
    idle_frame_a: assert property (s_ff.idle_pend && s_ff.te && s_ff.te_prev && !s_ff.send_break // RULE_04
        && !s_ff.tail_pend && s_ff.tx_state == astr_pkg::ASTR_TX_IDLE
        |=> s_ff.tx_shift == 11'h7ff ##1 tx_data_pin)
        else $error("idle frame not sent on enable");
    hold_discard_a: assert property (s_ff.te != s_ff.te_prev |=> s_ff.tx_buffer_empty) // RULE_06
        else $error("pending byte not discarded on enable toggle");
    rx_deliver_a: assert property (rx_done && !s_ff.rx_buffer_full // RULE_10
        |=> s_ff.rx_buffer_full && s_ff.rx_holding_buffer == $past(s_ff.rx_sh[7:0]))
        else $error("received byte not delivered");
    overrun_keep_a: assert property (rx_done && s_ff.rx_buffer_full && !data_rd_clr // RULE_15
        |=> s_ff.orf && $stable(s_ff.rx_holding_buffer))
        else $error("overrun lost holding data or flag");
    rx_clear_a: assert property (data_rd_clr && !rx_done // RULE_11
        |=> !s_ff.rx_buffer_full && !s_ff.orf && !s_ff.nf)
        else $error("receive flags not cleared by status and data read");
    noise_with_full_a: assert property ($rose(s_ff.nf) |-> $rose(s_ff.rx_buffer_full)) // RULE_19
        else $error("noise flag rose without receive full");
    false_start_a: assert property (rx_eval && s_ff.rx_state == astr_pkg::ASTR_RX_START // RULE_21
        && maj |=> s_ff.rx_state == astr_pkg::ASTR_RX_HUNT && !$rose(s_ff.rx_buffer_full))
        else $error("false start not discarded");
    idle_irq_a: assert property (s_ff.idle && s_ff.idle_line_irq_enable && !$past(irq_mask) |-> irq) // RULE_14
        else $error("idle interrupt missing");

    char_rx_c:   cover property (rx_done && !s_ff.rx_buffer_full);
    overrun_c:   cover property (rx_done && s_ff.rx_buffer_full);
    break_tx_c:  cover property (s_ff.tail_pend && !s_ff.send_break);
    noise_rx_c:  cover property ($rose(s_ff.nf));
    tx_frame_c:  cover property (s_ff.tx_count_done);

endmodule // astr_core

// [tb/astr_remote.sv]
`timescale 1ns/100ps
module astr_remote #(
    parameter int BIT = 16
) (
    input  wire logic       clk,
    input  wire logic       tx_line,
    output logic            rx_line,
    output logic [8:0]      got,
    output logic            got_v
);
    initial begin
        rx_line = 1'b1;
        got = 9'h000;
        got_v = 1'b0;
    end
    // start 0, data lsb first, stop 1; a glitch flips one mid sample of bit 0
    task automatic send(input logic [8:0] d, input int n, input bit glitch);
        logic b;
        for (int i = 0; i < n + 2; i++) begin
            b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : 1'b1;
            for (int k = 0; k < BIT; k++) begin
                @(posedge clk);
                rx_line <= (glitch && i == 1 && k == 8) ? ~b : b;
            end
        end
    endtask
    // low for half a bit: the start samples read 011, a false start
    task automatic blip();
        for (int k = 0; k < 24; k++) begin
            @(posedge clk);
            rx_line <= (k < 8) ? 1'b0 : 1'b1;
        end
    endtask
    always begin
        @(negedge tx_line);
        repeat (BIT / 2) @(posedge clk);
        if (tx_line === 1'b0) begin
            got <= 9'h000;
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk);
                got[i] <= tx_line;
            end
            repeat (BIT) @(posedge clk);
            got_v <= 1'b1;
            @(posedge clk);
            got_v <= 1'b0;
        end
    end
endmodule // astr_remote

// [tb/async_serial_tx_rx_core_tb.sv]
`timescale 1ns/100ps
module async_serial_tx_rx_core_tb;
    typedef struct packed { logic [7:0] v; logic [7:0] m; } astr_exp_t;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       irq_mask = 1'b0;
    logic       rx_line, tx_line, irq, got_v, rd_d = 1'b0;
    logic [7:0] rdata;
    logic [8:0] got;
    logic [7:0] b [0:5];
    logic [7:0] txq [$];
    astr_exp_t  expq [$];
    astr_exp_t  e;
    int         mismatches = 0, check_count = 0, cyc = 0, t0, nfr = 0;
    int         seed = 32'h6e5f;
    always #10 clk = ~clk;
    astr_core dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq_mask(irq_mask), .rx_data_pin(rx_line), .tx_data_pin(tx_line),
        .irq(irq));
    astr_remote #(.BIT(16)) remote_u (.clk(clk), .tx_line(tx_line), .rx_line(rx_line),
        .got(got), .got_v(got_v));
    task automatic check(input string n, input logic [7:0] x, input logic [7:0] s);
        check_count++;
        if (s !== x) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d check_count %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // expectation is queued by the driver; the monitor below takes it off
    task automatic rreg(input logic [2:0] a, input logic [7:0] v, input logic [7:0] m);
        expq.push_back('{v, m});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rx_wait();
        repeat (20) @(posedge clk);
    endtask
    always @(posedge clk) begin
        rd_d <= rd;
        cyc <= cyc + 1;
        if (rd_d) begin
            e = expq.pop_front();
            check("rdata", e.v, rdata & e.m);
        end
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    always @(posedge got_v) begin
        nfr++;
        check("tx_byte", txq.pop_front(), got[7:0]);
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) b[i] = 8'($random(seed));
        rreg(astr_pkg::ADDR_STATUS, 8'hc0, 8'hfe);
        rreg(3'h6, 8'h00, 8'hff);
        wreg(astr_pkg::ADDR_DIV_LO, 8'h01);
        wreg(astr_pkg::ADDR_DIV_HI, 8'h00);
        wreg(astr_pkg::ADDR_CTRL2, 8'h2c);
        t0 = cyc;
        rreg(astr_pkg::ADDR_STATUS, 8'h80, 8'h80);
        txq.push_back(b[0]);
        wreg(astr_pkg::ADDR_DATA, b[0]);
        rreg(astr_pkg::ADDR_STATUS, 8'h00, 8'hc0);
        for (int k = 0; k < 400 && tx_line === 1'b1; k++) @(posedge clk);
        check("idle_first", 8'h01, {7'h0, (cyc - t0) >= 160});
        // pending byte must vanish when the enable is toggled mid-frame
        rreg(astr_pkg::ADDR_STATUS, 8'hc0, 8'hc0);
        wreg(astr_pkg::ADDR_DATA, b[1]);
        wreg(astr_pkg::ADDR_CTRL2, 8'h24);
        wreg(astr_pkg::ADDR_CTRL2, 8'h2c);
        repeat (600) @(posedge clk);
        check("frames", 8'h01, nfr[7:0]);
        rreg(astr_pkg::ADDR_STATUS, 8'h40, 8'h40);
        // a break run holds the line low, so the remote sees one zero byte
        txq.push_back(8'h00);
        wreg(astr_pkg::ADDR_CTRL2, 8'h2d);
        repeat (200) @(posedge clk);
        wreg(astr_pkg::ADDR_CTRL2, 8'h2c);
        repeat (400) @(posedge clk);
        check("break_frames", 8'h02, nfr[7:0]);
        remote_u.send({1'b0, b[2]}, 8, 1'b0);
        rx_wait();
        check("irq", 8'h01, {7'h0, irq});
        rreg(astr_pkg::ADDR_STATUS, 8'h20, 8'h2e);
        rreg(astr_pkg::ADDR_DATA, b[2], 8'hff);
        rreg(astr_pkg::ADDR_STATUS, 8'h00, 8'h20);
        remote_u.send({1'b0, b[3]}, 8, 1'b0);
        remote_u.send({1'b0, b[4]}, 8, 1'b0);
        rx_wait();
        rreg(astr_pkg::ADDR_STATUS, 8'h28, 8'h28);
        rreg(astr_pkg::ADDR_DATA, b[3], 8'hff);
        rreg(astr_pkg::ADDR_STATUS, 8'h00, 8'h28);
        remote_u.send({1'b0, b[5]}, 8, 1'b1);
        rx_wait();
        rreg(astr_pkg::ADDR_STATUS, 8'h24, 8'h24);
        rreg(astr_pkg::ADDR_DATA, b[5], 8'hff);
        rreg(astr_pkg::ADDR_STATUS, 8'h00, 8'h24);
        irq_mask <= 1'b1;
        wreg(astr_pkg::ADDR_CTRL1, 8'h10);
        remote_u.blip();
        remote_u.send({1'b1, b[0]}, 9, 1'b0);
        rx_wait();
        check("irq_masked", 8'h00, {7'h0, irq});
        rreg(astr_pkg::ADDR_STATUS, 8'h24, 8'h2e);
        rreg(astr_pkg::ADDR_CTRL1, 8'h80, 8'h80);
        rreg(astr_pkg::ADDR_DATA, b[0], 8'hff);
        wreg(astr_pkg::ADDR_CTRL2, 8'h1c);
        irq_mask <= 1'b0;
        repeat (200) @(posedge clk);
        check("idle_irq", 8'h01, {7'h0, irq});
        rreg(astr_pkg::ADDR_STATUS, 8'h10, 8'h10);
        finish_test();
    end
endmodule // async_serial_tx_rx_core_tb
